// ### design/otp_page_params.svh
`ifndef OTP_PAGE_PARAMS_SVH
`define OTP_PAGE_PARAMS_SVH

// System clock.
`define CLK_PERIOD_NS      40

// Opcodes.
`define OP_OTP_PROG        8'h9B
`define OP_OTP_READ        8'h77
`define OP_XFR_B1          8'h53
`define OP_XFR_B2          8'h55
`define OP_CMP_B1          8'h60
`define OP_CMP_B2          8'h61
`define OP_RW_B1           8'h58
`define OP_RW_B2           8'h59
`define OP_STATUS_RD       8'hD7

// Security region layout.
`define OTP_USER_BYTES     8'd64
`define REGION_BYTES       8'd128
`define OTP_BLANK          8'hFF
`define TAIL_FILL          8'h00

// Page geometry and page index position in the address bytes.
`define PAGE_COUNT         4096
`define PAGE_BYTES_STD     11'd528
`define PAGE_BYTES_BIN     11'd512
`define STD_PAGE_MSB       21
`define STD_PAGE_LSB       10
`define BIN_PAGE_MSB       20
`define BIN_PAGE_LSB       9
`define ADDR_BYTES_DONE    8'd4

// Status byte fields.
`define STAT_RDY_BIT       7
`define STAT_COMP_BIT      6
`define DENSITY_CODE       4'hB
`define PROTECT_OFF        1'b0

// Reset values.
`define COMP_RST           1'b0
`define OTP_DONE_RST       1'b0

// Self-timed operation lengths; longest times, rounded down.
`define PAGE_COPY_TIME_NS  30000
`define PAGE_CHECK_TIME_NS 30000
`define OTP_WRITE_TIME_NS  4000
`define PAGE_REFRESH_TIME_NS 60000
`define PAGE_COPY_CYC    (`PAGE_COPY_TIME_NS / `CLK_PERIOD_NS)
`define PAGE_CHECK_CYC   (`PAGE_CHECK_TIME_NS / `CLK_PERIOD_NS)
`define OTP_WRITE_CYC    (`OTP_WRITE_TIME_NS / `CLK_PERIOD_NS)
`define PAGE_REFRESH_CYC (`PAGE_REFRESH_TIME_NS / `CLK_PERIOD_NS)

`endif

// ### design/otp_page_pkg.sv
package otp_page_pkg;

   typedef enum logic [5:0] {
      ST_IDLE    = 6'b00_0001,
      ST_ADDR    = 6'b00_0010,
      ST_OTPDATA = 6'b00_0100,
      ST_READ    = 6'b00_1000,
      ST_STATUS  = 6'b01_0000,
      ST_IGNORE  = 6'b10_0000
   } frame_state_t;

   typedef enum logic [4:0] {
      OP_IDLE = 5'b0_0001,
      OP_XFR  = 5'b0_0010,
      OP_CMP  = 5'b0_0100,
      OP_RW   = 5'b0_1000,
      OP_OTP  = 5'b1_0000
   } op_state_t;

   typedef struct packed {
      frame_state_t st;
      op_state_t    op;
      logic [7:0]   cmd;
      logic [7:0]   nb;
      logic [23:0]  addr;
      logic [7:0]   ptr;
      logic [15:0]  cnt;
      logic [11:0]  page;
      logic         bsel;
      logic         diff;
      logic         comp;
      logic         otp_done;
      logic [7:0]   tx_byte;
      logic         tx_en;
      logic         cs_s1;
      logic         cs_s2;
      logic         cs_s3;
      logic         tg_s1;
      logic         tg_s2;
      logic         tg_s3;
      logic         bin_s1;
      logic         bin_s2;
   } seq_regs_t;

   typedef struct packed {
      logic [2:0] bitcnt;
      logic       later;
      logic [6:0] sh_in;
      logic [7:0] rx_byte;
      logic       rx_tgl;
      logic [7:0] tx_sh;
      logic       drive;
   } link_regs_t;

endpackage : otp_page_pkg

// ### design/otp_page_sequencer.sv
`timescale 1ns/100ps
`include "otp_page_params.svh"
module otp_page_sequencer #(
   // Arbitrary seed for the factory unique bytes.
   parameter logic [7:0] UNIQUE_SEED = 8'hA5
) (
   // System
   input  wire logic clock,
   input  wire logic sys_rst,
   // Serial link
   input  wire logic sck,
   input  wire logic cs_n,
   input  wire logic si,
   output logic      so,
   output logic      so_oe,
   // Page size strap, high for 512-byte pages
   input  wire logic binary_page_mode,
   // Status view
   output logic      busy,
   output logic      comp_result
);

   localparam int PAGE_BYTES_ALL = `PAGE_COUNT * 528;
   localparam int XFR_LAST_I     = `PAGE_COPY_CYC - 1;
   localparam int CMP_LAST_I     = `PAGE_CHECK_CYC - 1;
   localparam int RW_LAST_I      = `PAGE_REFRESH_CYC - 1;
   localparam int OTP_LAST_I     = `OTP_WRITE_CYC - 1;

   otp_page_pkg::seq_regs_t r;
   otp_page_pkg::seq_regs_t n;

   logic [7:0]  main_mem [0:PAGE_BYTES_ALL-1];
   logic [7:0]  buf_mem  [0:1][0:527];
   logic [7:0]  otp_mem  [0:63];
   logic [7:0]  uniq     [0:63];

   logic [7:0]  rx_byte;
   logic        rx_tgl;
   logic        byte_stb;
   logic        cs_rise;
   logic        known_op;
   logic [7:0]  stat_b1;
   logic [7:0]  stat_b2;
   logic [7:0]  region_rd;
   logic [10:0] plen;
   logic [9:0]  off;
   logic [21:0] main_ra;
   logic [7:0]  main_rd;
   logic [7:0]  buf_rd;
   logic [15:0] op_last;
   logic        buf_we;
   logic        buf_sel;
   logic [9:0]  buf_addr;
   logic [7:0]  buf_wd;
   logic        main_we;
   logic [7:0]  main_wd;
   logic        otp_we;
   logic [5:0]  otp_addr;

   spi_byte_link u_link (
      .sck     (sck),
      .cs_n    (cs_n),
      .si      (si),
      .so      (so),
      .so_oe   (so_oe),
      .tx_byte (r.tx_byte),
      .tx_en   (r.tx_en),
      .rx_byte (rx_byte),
      .rx_tgl  (rx_tgl)
   );

   // Factory part has no write path at all.
   genvar g;
   generate
      for (g = 0; g < 64; g++) begin : g_uniq
         assign uniq[g] = UNIQUE_SEED ^ 8'(g * 37);
      end
   endgenerate

   assign busy        = (r.op != otp_page_pkg::OP_IDLE);
   assign comp_result = r.comp;
   assign byte_stb    = (r.tg_s2 != r.tg_s3) & ~r.cs_s2;
   assign cs_rise     = r.cs_s2 & ~r.cs_s3;
   assign stat_b1     = {~busy, r.comp, `DENSITY_CODE, `PROTECT_OFF, r.bin_s2};
   assign stat_b2     = {~busy, 7'h00};
   assign known_op    = rx_byte inside {`OP_XFR_B1, `OP_XFR_B2, `OP_CMP_B1,
                                        `OP_CMP_B2, `OP_RW_B1, `OP_RW_B2,
                                        `OP_OTP_READ, `OP_OTP_PROG};
   assign plen        = r.bin_s2 ? `PAGE_BYTES_BIN : `PAGE_BYTES_STD;
   assign off         = (r.cnt[10:0] >= plen) ? 10'(r.cnt[10:0] - plen)
                                              : r.cnt[9:0];
   assign main_ra     = 22'(r.page) * 22'(`PAGE_BYTES_STD) + 22'(off);
   assign main_rd     = main_mem[main_ra];
   assign buf_rd      = buf_mem[r.bsel][off];

   // An unprogrammed user part reads as blank.
   always_comb begin
      if (r.ptr < `OTP_USER_BYTES) begin
         region_rd = r.otp_done ? otp_mem[r.ptr[5:0]] : `OTP_BLANK;
      end else if (r.ptr < `REGION_BYTES) begin
         region_rd = uniq[r.ptr[5:0]];
      end else begin
         region_rd = `TAIL_FILL;
      end
   end

   always_comb begin
      case (r.op)
         otp_page_pkg::OP_XFR: op_last = 16'(XFR_LAST_I);
         otp_page_pkg::OP_CMP: op_last = 16'(CMP_LAST_I);
         otp_page_pkg::OP_RW:  op_last = 16'(RW_LAST_I);
         default:              op_last = 16'(OTP_LAST_I);
      endcase
   end

   always_comb begin
      n        = r;
      buf_we   = 1'b0;
      buf_sel  = r.bsel;
      buf_addr = off;
      buf_wd   = main_rd;
      main_we  = 1'b0;
      main_wd  = buf_rd;
      otp_we   = 1'b0;
      otp_addr = r.cnt[5:0];
      n.cs_s1  = cs_n;
      n.cs_s2  = r.cs_s1;
      n.cs_s3  = r.cs_s2;
      n.tg_s1  = rx_tgl;
      n.tg_s2  = r.tg_s1;
      n.tg_s3  = r.tg_s2;
      n.bin_s1 = binary_page_mode;
      n.bin_s2 = r.bin_s1;

      // Frame decoding.
      case (r.st)
         otp_page_pkg::ST_IDLE: begin
            n.tx_byte = stat_b1;
            n.tx_en   = 1'b0;
            if (byte_stb) begin
               n.cmd  = rx_byte;
               n.nb   = 8'd1;
               n.ptr  = 8'h00;
               n.addr = 24'h00_0000;
               if (rx_byte == `OP_STATUS_RD) begin
                  n.st      = otp_page_pkg::ST_STATUS;
                  n.tx_byte = stat_b2;
                  n.tx_en   = 1'b1;
                  n.ptr     = 8'h01;
               end else if (busy) begin
                  n.st = otp_page_pkg::ST_IGNORE;
               end else if (known_op) begin
                  n.st = otp_page_pkg::ST_ADDR;
               end else begin
                  n.st = otp_page_pkg::ST_IGNORE;
               end
            end
         end
         otp_page_pkg::ST_ADDR: begin
            if (byte_stb) begin
               n.addr = {r.addr[15:0], rx_byte};
               if (r.nb != 8'hFF) begin
                  n.nb = r.nb + 8'd1;
               end
               // Read data must be staged one byte ahead of the link.
               if (r.cmd == `OP_OTP_READ && r.nb >= 8'd2) begin
                  n.tx_byte = region_rd;
                  n.tx_en   = 1'b1;
                  n.ptr     = r.ptr + 8'd1;
               end
               if (r.cmd == `OP_OTP_PROG && rx_byte != 8'h00) begin
                  n.st = otp_page_pkg::ST_IGNORE;
               end else if (r.nb == 8'd3 && r.cmd == `OP_OTP_PROG) begin
                  n.st  = otp_page_pkg::ST_OTPDATA;
                  n.ptr = 8'h00;
               end else if (r.nb == 8'd3 && r.cmd == `OP_OTP_READ) begin
                  n.st = otp_page_pkg::ST_READ;
               end
            end
         end
         otp_page_pkg::ST_OTPDATA: begin
            if (byte_stb) begin
               buf_we    = 1'b1;
               buf_sel   = 1'b0;
               buf_addr  = {4'h0, r.ptr[5:0]};
               buf_wd    = rx_byte;
               n.ptr     = {2'b00, 6'(r.ptr[5:0] + 6'd1)};
            end
         end
         otp_page_pkg::ST_READ: begin
            if (byte_stb) begin
               n.tx_byte = region_rd;
               if (r.ptr != `REGION_BYTES) begin
                  n.ptr = r.ptr + 8'd1;
               end
            end
         end
         otp_page_pkg::ST_STATUS: begin
            if (byte_stb) begin
               n.tx_byte = r.ptr[0] ? stat_b1 : stat_b2;
               n.ptr     = {7'h00, ~r.ptr[0]};
            end
         end
         otp_page_pkg::ST_IGNORE: begin
            n.tx_en = 1'b0;
         end
         default: begin
            n.st = otp_page_pkg::ST_IDLE;
         end
      endcase

      // Deselect closes the frame and may launch a timed operation.
      if (cs_rise) begin
         n.st    = otp_page_pkg::ST_IDLE;
         n.tx_en = 1'b0;
         // A status frame that ends mid-operation must leave its operands.
         if (!busy) begin
            n.cnt  = 16'h0000;
            n.diff = 1'b0;
            n.page = r.bin_s2 ? r.addr[`BIN_PAGE_MSB:`BIN_PAGE_LSB]
                              : r.addr[`STD_PAGE_MSB:`STD_PAGE_LSB];
            n.bsel = (r.cmd == `OP_XFR_B2) || (r.cmd == `OP_CMP_B2) ||
                     (r.cmd == `OP_RW_B2);
         end
         if (r.st == otp_page_pkg::ST_ADDR && r.nb >= `ADDR_BYTES_DONE &&
             !busy) begin
            case (r.cmd)
               `OP_XFR_B1, `OP_XFR_B2: n.op = otp_page_pkg::OP_XFR;
               `OP_CMP_B1, `OP_CMP_B2: n.op = otp_page_pkg::OP_CMP;
               `OP_RW_B1, `OP_RW_B2:   n.op = otp_page_pkg::OP_RW;
               default:                n.op = r.op;
            endcase
         end else if (r.st == otp_page_pkg::ST_OTPDATA && !r.otp_done &&
                      !busy) begin
            n.op   = otp_page_pkg::OP_OTP;
            n.bsel = 1'b0;
         end
      end

      // Self-timed operations walk one byte per clock, then wait out time.
      case (r.op)
         otp_page_pkg::OP_IDLE: begin
            n.cnt = r.cnt;
         end
         otp_page_pkg::OP_XFR: begin
            buf_we = (r.cnt[10:0] < plen);
         end
         otp_page_pkg::OP_CMP: begin
            if (r.cnt[10:0] < plen && main_rd != buf_rd) begin
               n.diff = 1'b1;
            end
         end
         otp_page_pkg::OP_RW: begin
            buf_we  = (r.cnt[10:0] < plen);
            main_we = (r.cnt[10:0] >= plen) && (r.cnt[11:0] < {plen, 1'b0});
         end
         otp_page_pkg::OP_OTP: begin
            // Whatever buffer 1 holds is burnt, received or not.
            otp_we = (r.cnt < 16'(`OTP_USER_BYTES));
         end
         default: begin
            n.op = otp_page_pkg::OP_IDLE;
         end
      endcase
      if (busy) begin
         if (r.cnt == op_last) begin
            n.op  = otp_page_pkg::OP_IDLE;
            n.cnt = 16'h0000;
            if (r.op == otp_page_pkg::OP_CMP) begin
               n.comp = r.diff;
            end
            if (r.op == otp_page_pkg::OP_OTP) begin
               n.otp_done = 1'b1;
            end
         end else begin
            n.cnt = r.cnt + 16'd1;
         end
      end
   end

   // A plain always block leaves the arrays open to a hierarchical preload.
   always @(posedge clock) begin
      if (buf_we) begin
         buf_mem[buf_sel][buf_addr] <= buf_wd;
      end
      if (main_we) begin
         main_mem[main_ra] <= main_wd;
      end
      if (otp_we) begin
         otp_mem[otp_addr] <= buf_mem[0][otp_addr];
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         r          <= '0;
         r.st       <= otp_page_pkg::ST_IDLE;
         r.op       <= otp_page_pkg::OP_IDLE;
         r.comp     <= `COMP_RST;
         r.otp_done <= `OTP_DONE_RST;
         r.cs_s1    <= 1'b1;
         r.cs_s2    <= 1'b1;
         r.cs_s3    <= 1'b1;
      end else begin
         r <= n;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   property p_xfr_time;
      (r.op == otp_page_pkg::OP_XFR) ##1 (r.op != otp_page_pkg::OP_XFR)
         |-> $past(r.cnt) == 16'(XFR_LAST_I);
   endproperty
   a_xfr_time: assert property (p_xfr_time)
      else $error("page copy ended at the wrong cycle");

   property p_ready_low;
      (r.op != otp_page_pkg::OP_IDLE) |-> !stat_b1[`STAT_RDY_BIT] &&
                                          !stat_b2[`STAT_RDY_BIT];
   endproperty
   a_ready_low: assert property (p_ready_low)
      else $error("ready bit high during an operation");

   property p_comp_result;
      (r.op == otp_page_pkg::OP_CMP) ##1 (r.op == otp_page_pkg::OP_IDLE)
         |-> r.comp == $past(r.diff);
   endproperty
   a_comp_result: assert property (p_comp_result)
      else $error("compare bit does not hold the compare outcome");

   property p_otp_refuse;
      (cs_rise && r.st == otp_page_pkg::ST_OTPDATA && r.otp_done && !busy)
         |=> r.op == otp_page_pkg::OP_IDLE;
   endproperty
   a_otp_refuse: assert property (p_otp_refuse)
      else $error("programmed user part accepted another program");

   property p_busy_refuse;
      (busy && byte_stb && r.st == otp_page_pkg::ST_IDLE &&
       rx_byte != `OP_STATUS_RD) |=> r.st == otp_page_pkg::ST_IGNORE;
   endproperty
   a_busy_refuse: assert property (p_busy_refuse)
      else $error("command accepted while busy");

   property p_wrap;
      (r.st == otp_page_pkg::ST_OTPDATA && byte_stb && r.ptr == 8'd63)
         |=> r.ptr == 8'd0;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("data pointer did not wrap to zero");

   property p_buf1_used;
      (r.st == otp_page_pkg::ST_OTPDATA && byte_stb)
         |-> buf_we && !buf_sel && buf_wd == rx_byte;
   endproperty
   a_buf1_used: assert property (p_buf1_used)
      else $error("security data not stored in buffer 1");

   property p_tail_fill;
      (r.st == otp_page_pkg::ST_READ && byte_stb && r.ptr >= 8'd128)
         |=> r.tx_byte == `TAIL_FILL;
   endproperty
   a_tail_fill: assert property (p_tail_fill)
      else $error("data past the region end is not the fill value");

   property p_unknown_op;
      (r.st == otp_page_pkg::ST_IDLE && byte_stb && !known_op &&
       rx_byte != `OP_STATUS_RD) |=> r.st == otp_page_pkg::ST_IGNORE;
   endproperty
   a_unknown_op: assert property (p_unknown_op)
      else $error("unknown opcode was not ignored");

   property p_rw_program;
      (r.op == otp_page_pkg::OP_RW && r.cnt == 16'(`PAGE_BYTES_STD))
         |-> main_we && !buf_we;
   endproperty
   a_rw_program: assert property (p_rw_program)
      else $error("rewrite not programming in its second phase");

   c_xfr_done: cover property ((r.op == otp_page_pkg::OP_XFR) ##1
                               (r.op == otp_page_pkg::OP_IDLE));
   c_cmp_miss: cover property ((r.op == otp_page_pkg::OP_CMP) ##1
                               (r.op == otp_page_pkg::OP_IDLE && r.comp));
   c_otp_done: cover property ($rose(r.otp_done));
   c_stat_busy: cover property (busy && r.st == otp_page_pkg::ST_STATUS);

endmodule : otp_page_sequencer

// ### design/spi_byte_link.sv
`timescale 1ns/100ps
`include "otp_page_params.svh"
module spi_byte_link (
   // Serial pins
   input  wire logic       sck,
   input  wire logic       cs_n,
   input  wire logic       si,
   output logic            so,
   output logic            so_oe,
   // Byte exchange with the sequencer
   input  wire logic [7:0] tx_byte,
   input  wire logic       tx_en,
   output logic [7:0]      rx_byte,
   output logic            rx_tgl
);

   otp_page_pkg::link_regs_t r;
   otp_page_pkg::link_regs_t n;
   logic [7:0]               byte_in;

   // The sequencer holds tx_byte and tx_en steady for a whole byte after
   // each rx_tgl change, so sampling them at the byte boundary is safe.
   always_comb begin
      n         = r;
      byte_in   = {r.sh_in, si};
      n.sh_in   = byte_in[6:0];
      n.bitcnt  = r.bitcnt + 3'd1;
      n.tx_sh   = {r.tx_sh[6:0], 1'b0};
      if (r.bitcnt == 3'd7) begin
         n.rx_byte = byte_in;
         n.rx_tgl  = ~r.rx_tgl;
         n.later   = 1'b1;
         n.tx_sh   = tx_byte;
         // A status read must answer straight after its opcode, before the
         // sequencer could have seen it.
         n.drive   = tx_en | (~r.later & (byte_in == `OP_STATUS_RD));
      end
   end

   // Deselect clears the frame and releases the data-out pin.
   always_ff @(posedge sck or posedge cs_n) begin
      if (cs_n) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign so      = r.tx_sh[7];
   assign so_oe   = r.drive;
   assign rx_byte = r.rx_byte;
   assign rx_tgl  = r.rx_tgl;

endmodule : spi_byte_link

// ### testbench/otp_region_and_page_buffer_ops_bench.sv
`timescale 1ns/100ps
module otp_region_and_page_buffer_ops_bench;
   localparam logic [7:0] SEED = 8'h3C; // Arbitrary factory seed.
   logic       clock = 1'b0;
   logic       sys_rst = 1'b1;
   logic       binary_page_mode = 1'b0;
   logic       sck, cs_n, si, so, so_oe, busy, comp_result;
   int         n_mismatch = 0;
   int         checked = 0;
   int         cyc = 0;
   logic [7:0] rx, d;
   logic [7:0] wr [64];
   logic [11:0] pg, pa;
   logic [7:0] ops [6] = '{8'h53, 8'h55, 8'h60, 8'h61, 8'h58, 8'h59};
   int         lens [6] = '{750, 750, 750, 750, 1500, 1500};

   always #20 clock = ~clock;

   otp_page_sequencer #(.UNIQUE_SEED(SEED)) dut (
      .clock(clock), .sys_rst(sys_rst), .sck(sck), .cs_n(cs_n),
      .si(si), .so(so), .so_oe(so_oe),
      .binary_page_mode(binary_page_mode), .busy(busy),
      .comp_result(comp_result));
   // A released data-out line shows a wrong level, so late sampling fails.
   spi_host host (.sck(sck), .cs_n(cs_n), .si(si), .so(so_oe ? so : ~so));

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic print_verdict();
      if (n_mismatch == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : print_verdict

   function automatic logic [7:0] exp_byte(int i, logic p);
      logic [7:0] f;
      f = 8'((i - 64) * 37);
      if (i >= 128)
         return 8'h00;
      if (i >= 64)
         return SEED ^ f;
      return p ? wr[i] : 8'hFF;
   endfunction : exp_byte

   task automatic cmd(input logic [7:0] op, input logic [23:0] a);
      host.start();
      host.xfer(op, rx);
      host.xfer(a[23:16], rx);
      host.xfer(a[15:8], rx);
      host.xfer(a[7:0], rx);
   endtask : cmd

   // Busy is sampled on the falling edge, away from its update edge.
   task automatic run_len(input int exp);
      int n;
      int w;
      n = 0;
      w = 0;
      while (busy !== 1'b1 && w < 20) begin
         @(negedge clock);
         w++;
      end
      while (busy === 1'b1 && n < 2000) begin
         @(negedge clock);
         n++;
      end
      chk(16'(n), 16'(exp));
   endtask : run_len

   task automatic status(input logic rdy, input logic cmp);
      host.start();
      host.xfer(8'hD7, rx);
      host.xfer(8'h00, rx);
      host.stop();
      chk(16'(rx[7]), 16'(rdy));
      chk(16'(rx[6]), 16'(cmp));
      chk(16'(comp_result), 16'(cmp));
      chk(16'(rx[5:0]), 16'({4'hB, 1'b0, binary_page_mode}));
   endtask : status

   // Page p holds p + i at byte i, so neighbouring pages differ everywhere.
   task automatic preload(input logic [11:0] p);
      for (int i = 0; i < 528; i++)
         dut.main_mem[p * 528 + i] = 8'(p + i);
   endtask : preload

   task automatic read_region(input logic p);
      cmd(8'h77, 24'h00_0000);
      for (int i = 0; i < 129; i++) begin
         host.xfer(8'h00, rx);
         chk(16'(rx), 16'(exp_byte(i, p)));
      end
      chk(16'(so_oe), 16'h0001);
      host.stop();
      #1;
      chk(16'(so_oe), 16'h0000);
   endtask : read_region

   always @(posedge clock) begin
      cyc++;
      if (cyc == 40000) begin
         n_mismatch++;
         print_verdict();
      end
   end

   initial begin
      void'($urandom(74));
      repeat (20) @(posedge clock);
      sys_rst <= 1'b0;
      @(negedge clock);
      chk(16'(busy), 16'h0000);
      chk(16'(comp_result), 16'h0000);
      read_region(1'b0);
      cmd(8'h9B, 24'h00_0000);
      // Sixty-five bytes: the last one lands on location zero.
      for (int i = 0; i < 65; i++) begin
         d = 8'($urandom);
         host.xfer(d, rx);
         wr[i % 64] = d;
      end
      host.stop();
      run_len(100);
      read_region(1'b1);
      cmd(8'h9B, 24'h00_0000);
      host.xfer(8'h5A, rx);
      host.stop();
      run_len(0);
      read_region(1'b1);
      cmd(8'hA3, 24'($urandom));
      host.stop();
      run_len(0);
      // Copies and compares share one page size; only k == 3 misses.
      for (int k = 0; k < 6; k++) begin
         @(posedge clock);
         if (k % 4 == 0)
            binary_page_mode <= 1'($urandom);
         if (k == 0) begin
            pg = 12'($urandom);
            preload(pg);
            preload(12'(pg + 1));
         end
         pa = (k == 3) ? 12'(pg + 1) : pg;
         @(posedge clock);
         if (binary_page_mode)
            cmd(ops[k], {3'b000, pa, 9'h000});
         else
            cmd(ops[k], {2'b00, pa, 10'h000});
         host.stop();
         fork
            run_len(lens[k]);
            begin
               status(1'b0, k >= 4);
               cmd(8'h53, 24'h00_0000);
               host.stop();
            end
         join
         run_len(0);
         status(1'b1, k >= 3);
      end
      print_verdict();
   end
endmodule : otp_region_and_page_buffer_ops_bench

// ### testbench/spi_host.sv
`timescale 1ns/100ps
module spi_host (
   // Serial pins toward the device
   output logic      sck,
   output logic      cs_n,
   output logic      si,
   input  wire logic so
);
   // A short select pulse clears the link state of the device at power-up.
   initial begin
      sck = 1'b0;
      si = 1'b0;
      cs_n = 1'b0;
      #1;
      cs_n = 1'b1;
   end

   // The gap before select keeps deselect time between frames.
   task automatic start();
      #400;
      cs_n = 1'b0;
      #80;
   endtask : start

   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         si = tx[i];
         #80;
         rx[i] = so;
         sck = 1'b1;
         #80;
         sck = 1'b0;
      end
   endtask : xfer

   // Clock stays still after the frame and data in flips.
   task automatic stop();
      #160;
      cs_n = 1'b1;
      si = ~si;
   endtask : stop
endmodule : spi_host
